// *** rtl/fsbap_consts.svh ***
/*
 * Constants of the address-phase block: bus widths, bit positions, reset values.
 * Assumes inclusion by the package and the address-phase module only.
 */
`ifndef FSBAP_CONSTS_SVH
`define FSBAP_CONSTS_SVH

`define FSBAP_ADDR_MSB 35
`define FSBAP_ADDR_LSB 3
`define FSBAP_PHYS_BITS 36
`define FSBAP_REQ_BITS 5
`define FSBAP_MASK_BIT 20
`define FSBAP_PAR_SPLIT 24
`define FSBAP_CFG_BITS 8
`define FSBAP_CFG_RESET 8'h00
`define FSBAP_SYNC_STAGES 2

`endif

// *** rtl/fsbap_pkg.sv ***
/*
 * Types shared by the address-phase block.
 * Assumes the constants header sits beside it in rtl/.
 */
`include "fsbap_consts.svh"

package fsbap_pkg;

    typedef logic [`FSBAP_ADDR_MSB:`FSBAP_ADDR_LSB] fsbap_addr_type;

    // one request as handed in by the core or captured from the bus
    typedef struct packed {
        fsbap_addr_type addr;
        logic [`FSBAP_REQ_BITS-1:0] req;
    } fsbap_req_type;

    // pins driven during an address phase
    typedef struct packed {
        fsbap_addr_type addr;
        logic [`FSBAP_REQ_BITS-1:0] req;
        logic [1:0] parity;
        logic valid_strobe;
        logic [1:0] strobes;
    } fsbap_pins_type;

    typedef enum logic [3:0] {
        FSBAP_IDLE = 4'h1,
        FSBAP_SUB1 = 4'h2,
        FSBAP_SUB2 = 4'h4,
        FSBAP_DONE = 4'h8
    } fsbap_state_type;

endpackage : fsbap_pkg

// *** rtl/fsbap_address_phase.sv ***
/*
 * Address-phase logic of a front side bus agent: drives and receives the
 * address lines, valid strobe, source-synchronous strobes and parity, and
 * applies the bit-20 mask. Pins are active high here; any active-low pad
 * inversion lives outside. Inputs from pins are async to core_clk.
 * Limitations: subphase two reuses the subphase one parity grouping, and
 * only strobe bit 0 is watched on receive.
 */
`timescale 1ns/1ps
`include "fsbap_consts.svh"

// Behaviour
// - address in subphase 1, request type in subphase 2 on address lines
// - address lines span bits 35 to 3, a 36-bit physical space
// - two parity bits cover address lines; generated on send, checked on receive
// - received address captured by the address strobes, not the bus clock; here sampled on core_clk at a detected synchronised strobe edge
// - at reset release, sample address lines into power-on configuration
// - mask forces address bit 20 low before lookup and bus drive
// - mask honoured only in real mode
// - requester asserts valid strobe when address and request lines are valid
// - valid strobe starts parity check and decode of the new transaction
// - parity bit high when even count of covered signals low
module fsbap_address_phase
    import fsbap_pkg::*;
#(
    parameter int CFG_LSB = `FSBAP_ADDR_LSB
) (
    input wire logic core_clk,
    input wire logic nrst,
    // core request side
    input wire logic core_req_valid,
    input wire fsbap_req_type core_req,
    output logic core_req_ready,
    input wire logic real_mode,
    output fsbap_addr_type lookup_addr,
    // bus pins
    input wire logic addr_bit20_mask,
    input wire fsbap_pins_type bus_in,
    output fsbap_pins_type bus_out,
    output logic bus_oe,
    // received transaction and power-on straps
    output logic rx_valid,
    output fsbap_req_type rx_req,
    output logic rx_parity_err,
    output logic [`FSBAP_CFG_BITS-1:0] power_on_cfg
);

    // parity: high when an even number of covered signals are low
    function automatic logic [1:0] par_of(input fsbap_addr_type a,
                                          input logic [`FSBAP_REQ_BITS-1:0] r);
        logic hi;
        logic lo;
        hi = ~^(~a[`FSBAP_ADDR_MSB:`FSBAP_PAR_SPLIT]);
        lo = ~^({~a[`FSBAP_PAR_SPLIT-1:`FSBAP_ADDR_LSB], ~r});
        par_of = {lo, hi};
    endfunction : par_of

    // pin synchroniser without reset, so straps on the address lines
    // reach the second stage while reset is still held
    fsbap_pins_type pin_s1_q;
    fsbap_pins_type pin_s2_q;
    always_ff @(posedge core_clk) begin
        pin_s1_q <= bus_in;
        pin_s2_q <= pin_s1_q;
    end

    // mask synchroniser; cleared so no stale mask acts after reset
    logic mask_s1_q;
    logic mask_s2_q;
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            mask_s1_q <= 1'b0;
            mask_s2_q <= 1'b0;
        end else begin
            mask_s1_q <= addr_bit20_mask;
            mask_s2_q <= mask_s1_q;
        end
    end

    // masked address feeds both cache lookup and bus drive
    fsbap_addr_type masked_addr;
    always_comb begin
        masked_addr = core_req.addr;
        if (mask_s2_q && real_mode) begin
            masked_addr[`FSBAP_MASK_BIT] = 1'b0;
        end
    end
    assign lookup_addr = masked_addr;

    // transmit sequencer: one state per subphase, between idle and a gap state
    fsbap_state_type state_q;
    fsbap_req_type held_q;
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            state_q <= FSBAP_IDLE;
            held_q <= '0;
        end else begin
            case (state_q)
                FSBAP_IDLE: begin
                    if (core_req_valid) begin
                        held_q <= '{addr: masked_addr, req: core_req.req};
                        state_q <= FSBAP_SUB1;
                    end
                end
                FSBAP_SUB1: state_q <= FSBAP_SUB2;
                FSBAP_SUB2: state_q <= FSBAP_DONE;
                FSBAP_DONE: state_q <= FSBAP_IDLE; // gap keeps strobes clean
                default: state_q <= FSBAP_IDLE;
            endcase
        end
    end
    // ready only in idle; a request held through busy cycles simply waits
    assign core_req_ready = (state_q == FSBAP_IDLE);

    // pin drive, registered; type info rides the low bits in subphase 2
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            bus_out <= '0;
            bus_oe <= 1'b0;
        end else begin
            bus_oe <= (state_q == FSBAP_SUB1) || (state_q == FSBAP_SUB2);
            bus_out <= '0;
            if (state_q == FSBAP_SUB1) begin
                bus_out.addr <= held_q.addr;
                bus_out.req <= held_q.req;
                bus_out.parity <= par_of(held_q.addr, held_q.req);
                bus_out.valid_strobe <= 1'b1;
                bus_out.strobes <= 2'h3; // rising edge, first transfer
            end else if (state_q == FSBAP_SUB2) begin
                bus_out.addr <= fsbap_addr_type'(held_q.req);
                bus_out.req <= held_q.req;
                bus_out.parity <= par_of(fsbap_addr_type'(held_q.req), held_q.req);
                bus_out.strobes <= 2'h0; // falling edge, second transfer
            end
        end
    end

    // receive: strobe and valid edges found on the synchronised copies
    logic strb_prev_q;
    logic vs_prev_q;
    logic strb_rise;
    logic strb_fall;
    logic vs_fall;
    logic rx_take;
    assign strb_rise = pin_s2_q.strobes[0] && !strb_prev_q;
    assign strb_fall = !pin_s2_q.strobes[0] && strb_prev_q;
    assign vs_fall = !pin_s2_q.valid_strobe && vs_prev_q;
    // own drive would echo back through the pads, so receive only when released
    assign rx_take = strb_rise && pin_s2_q.valid_strobe && !bus_oe;

    // previous levels, reset to the idle level so no false edge follows reset
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            strb_prev_q <= 1'b0;
            vs_prev_q <= 1'b0;
        end else begin
            strb_prev_q <= pin_s2_q.strobes[0];
            vs_prev_q <= pin_s2_q.valid_strobe;
        end
    end

    // subphase tracking; a frame cut before its second edge is dropped,
    // else a stale first half would pair with a later falling edge
    logic sub1_seen_q;
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            sub1_seen_q <= 1'b0;
        end else if (rx_take) begin
            sub1_seen_q <= 1'b1;
        end else if (strb_fall || vs_fall) begin
            sub1_seen_q <= 1'b0;
        end
    end

    // captured request: address on the rising edge, type on the falling one
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            rx_req <= '0;
        end else if (rx_take) begin
            rx_req.addr <= pin_s2_q.addr;
        end else if (strb_fall && sub1_seen_q) begin
            rx_req.req <= pin_s2_q.addr[`FSBAP_ADDR_LSB+`FSBAP_REQ_BITS-1:
                                         `FSBAP_ADDR_LSB];
        end
    end

    // completion pulse, one cycle per full two-edge phase
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            rx_valid <= 1'b0;
        end else begin
            rx_valid <= strb_fall && sub1_seen_q;
        end
    end

    // parity checked on the first transfer, where the address is covered
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            rx_parity_err <= 1'b0;
        end else begin
            rx_parity_err <= rx_take
                && (pin_s2_q.parity != par_of(pin_s2_q.addr, pin_s2_q.req));
        end
    end

    // power-on straps taken from the synchronised lines at the first edge
    // after reset release; the system holds them steady through reset
    logic in_reset_q;
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            in_reset_q <= 1'b1;
            power_on_cfg <= `FSBAP_CFG_RESET;
        end else begin
            in_reset_q <= 1'b0;
            if (in_reset_q) begin
                power_on_cfg <= pin_s2_q.addr[CFG_LSB +: `FSBAP_CFG_BITS];
            end
        end
    end

endmodule : fsbap_address_phase

// *** bench/fsbap_ap_checker.sv ***
/* Port assertions for the address-phase block.
   Assumes a bind into fsbap_address_phase and a two-stage mask sync. */
`timescale 1ns/1ps
module fsbap_ap_checker
    import fsbap_pkg::*;
#(
    parameter int CFG_LSB = 3
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic core_req_valid,
    input wire fsbap_req_type core_req,
    input wire logic core_req_ready,
    input wire logic real_mode,
    input wire fsbap_addr_type lookup_addr,
    input wire logic addr_bit20_mask,
    input wire fsbap_pins_type bus_in,
    input wire fsbap_pins_type bus_out,
    input wire logic bus_oe,
    input wire logic [7:0] power_on_cfg
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    // a taken request owns the pins for exactly two cycles
    walk_order_a: assert property (core_req_valid && core_req_ready |=>
        (!core_req_ready && !bus_oe) ##1 (bus_oe && !core_req_ready) [*2]
        ##1 (!bus_oe && core_req_ready)) else $error("walk order broken");
    sub1_strobe_a: assert property ($rose(bus_oe) |-> bus_out.valid_strobe &&
        bus_out.strobes == 2'h3) else $error("subphase one strobes wrong");
    sub_addr_a: assert property (core_req_valid && core_req_ready |-> ##2
        bus_out.addr == $past(lookup_addr, 2) ##1 bus_out.strobes == 2'h0
        && bus_out.addr == fsbap_addr_type'($past(core_req.req, 3))) else $error("subphase");
    parity_out_a: assert property ($rose(bus_oe) |-> bus_out.parity ==
        {$countones(~{bus_out.addr[23:3], bus_out.req}) % 2 == 0,
        $countones(~bus_out.addr[35:24]) % 2 == 0}) else $error("parity");
    // the sync stages need two clean edges before the mask counts
    mask_bit_a: assert property (real_mode && $past(addr_bit20_mask, 2) && $past(nrst)
        && $past(nrst, 2) |-> !lookup_addr[20]) else $error("bit 20 not masked");
    no_mask_a: assert property (!real_mode |-> lookup_addr == core_req.addr)
        else $error("address altered");
    strap_load_a: assert property ($rose(nrst) |=>
        power_on_cfg == $past(bus_in.addr[CFG_LSB +: 8], 3)) else $error("strap not loaded");
    strap_hold_a: assert property ($past(nrst) && $past(nrst, 2) |->
        $stable(power_on_cfg)) else $error("strap changed");
endmodule : fsbap_ap_checker

bind fsbap_address_phase fsbap_ap_checker #(.CFG_LSB(CFG_LSB)) fsbap_ap_checker_inst (
    .core_clk, .nrst, .core_req_valid, .core_req, .core_req_ready, .real_mode,
    .lookup_addr, .addr_bit20_mask, .bus_in, .bus_out, .bus_oe, .power_on_cfg);

// *** bench/fsbap_far_agent.sv ***
/* Far bus agent: straps and one inbound address phase.
   Assumes active-high pins and a strobe period of 48 ns. */
`timescale 1ns/1ps
module fsbap_far_agent
    import fsbap_pkg::*;
(
    output fsbap_pins_type bus_in
);
    initial bus_in = '0;
    task automatic strap(fsbap_addr_type a);
        bus_in.addr = a;
    endtask : strap
    // strobes stand still outside the frame; released lines flip
    task automatic send(fsbap_addr_type a, logic [4:0] r, logic bad);
        #4 bus_in.addr = a;
        bus_in.req = r;
        bus_in.parity = {$countones(~{a[23:3], r}) % 2 == 0,
            bad ^ ($countones(~a[35:24]) % 2 == 0)};
        bus_in.valid_strobe = 1'b1;
        #24 bus_in.strobes = 2'h3;
        #24 bus_in.addr = fsbap_addr_type'(r);
        bus_in.strobes = 2'h0;
        #24 bus_in.valid_strobe = 1'b0;
        bus_in.addr = ~bus_in.addr;
    endtask : send
endmodule : fsbap_far_agent

// *** bench/testbench.sv ***
/* Self-checking bench: random requests out, far-agent phases in.
   Assumes the design, checker and far agent are compiled first. */
`timescale 1ns/1ps
module testbench
    import fsbap_pkg::*;
;
    logic core_clk = 0, nrst = 0, core_req_valid = 0, real_mode = 0, addr_bit20_mask = 0;
    fsbap_req_type core_req = '0, rx_req, r;
    fsbap_addr_type lookup_addr;
    fsbap_pins_type bus_in, bus_out;
    logic core_req_ready, bus_oe, rx_valid, rx_parity_err;
    logic [7:0] power_on_cfg;
    int n_mismatch = 0, n_tests = 0, cyc = 0, n_err = 0, n_rx = 0, k, kr;
    fsbap_address_phase fsbap_address_phase_inst (.core_clk, .nrst, .core_req_valid,
        .core_req, .core_req_ready, .real_mode, .lookup_addr, .addr_bit20_mask, .bus_in,
        .bus_out, .bus_oe, .rx_valid, .rx_req, .rx_parity_err, .power_on_cfg);
    fsbap_far_agent fsbap_far_agent_inst (.bus_in);
    initial forever #2.5 core_clk = ~core_clk;
    task automatic check(string what, logic [63:0] seen, logic [63:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic tally_and_finish();
        if (n_mismatch == 0 && n_tests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : tally_and_finish
    // watchdog; error pulses stand one cycle, so count at every edge
    always @(posedge core_clk) begin
        cyc++;
        if (rx_parity_err === 1'b1) n_err++;
        if (rx_valid === 1'b1) n_rx++;
        if (cyc == 5000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end
    function automatic fsbap_pins_type sub1(fsbap_req_type q, logic m);
        sub1 = '{q.addr & ~(fsbap_addr_type'(m) << 17), q.req, 2'h0, 1'b1, 2'h3};
        sub1.parity = {$countones(~{sub1.addr[23:3], q.req}) % 2 == 0,
            $countones(~sub1.addr[35:24]) % 2 == 0};
    endfunction : sub1
    // mask set three edges ahead so the sync stages have settled
    task automatic request(fsbap_req_type q, logic rm, logic m);
        @(posedge core_clk);
        real_mode <= rm;
        addr_bit20_mask <= m;
        core_req <= q;
        repeat (3) @(posedge core_clk);
        core_req_valid <= 1'b1;
        @(posedge core_clk);
        core_req_valid <= 1'b0;
        @(posedge core_clk);
        #1 check("sub1", 64'(bus_out), 64'(sub1(q, rm && m)));
        @(posedge core_clk);
        #1 check("sub2", 64'(bus_out.addr), 64'(q.req));
    endtask : request
    initial begin
        void'($urandom(32'h06EAF11D));
        @(posedge core_clk);
        fsbap_far_agent_inst.strap(fsbap_addr_type'({$urandom(), $urandom()}));
        repeat (11) @(posedge core_clk);
        nrst <= 1'b1;
        repeat (2) @(posedge core_clk);
        #1 check("cfg", 64'(power_on_cfg), 64'(bus_in.addr[10:3]));
        for (int i = 0; i < 40; i++) begin
            r.addr = (i < 2) ? '1 : fsbap_addr_type'({$urandom(), $urandom()});
            r.req = 5'($urandom());
            request(r, 1'(i < 2 ? 1 : $urandom()), 1'(i < 1 ? 1 : $urandom()));
        end
        for (int i = 0; i < 16; i++) begin
            r.addr = fsbap_addr_type'({$urandom(), $urandom()});
            r.req = 5'($urandom());
            k = n_err;
            kr = n_rx;
            @(posedge core_clk);
            fsbap_far_agent_inst.send(r.addr, r.req, 1'(i));
            repeat (8) @(posedge core_clk);
            #1 check("rx_req", 64'(rx_req), 64'(r));
            check("rx_perr", 64'(n_err - k), 64'(i % 2));
            check("rx_valid", 64'(n_rx - kr), 64'(1));
        end
        tally_and_finish();
    end
endmodule : testbench
